// ==== src/vscsp_pkg.sv ====
/*
 * types of the vme slave control and status port.
 * assumes vscsp_regs.svh is on the include path.
 */
`include "vscsp_regs.svh"

package vscsp_pkg;

    // ------------------------------------------------------------
    // cycle handling states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        VSCSP_IDLE = 2'b00,
        VSCSP_ACK = 2'b01,
        VSCSP_WAIT_END = 2'b11
    } vscsp_state_t;

    // vme cycle request after synchronisation
    typedef struct packed
    {
        logic strobe;
        logic write;
        logic word;
        logic iack;
        logic [5:0] am;
        logic [23:1] addr;
        logic lds;
        logic uds;
        logic [15:0] wdata;
    } vscsp_vme_req_t;

    // local side status inputs
    typedef struct packed
    {
        logic cpu_reset_n;
        logic cpu_halt_n;
        logic wdog_ok;
    } vscsp_local_t;

    // state of the port, apart from the synchronisers and the ram select flop
    typedef struct packed
    {
        vscsp_state_t state;
        logic dtack;
        logic [15:0] rdata;
        logic data_oe;
        logic nmi_pulse;
        logic restart_active;
        logic [`VSCSP_CNT_W-1:0] restart_cnt;
        logic [3:0] irq_pend;
        logic [3:0][2:0] irq_level;
        logic [3:0] irq_enable;
        logic [3:0][7:0] irq_vector;
        logic [7:1] irq_out;
        logic sel_led;
        logic bim_cs;
    } vscsp_state_bundle_t;

endpackage

// ==== src/vscsp_port.sv ====
/*
 * vme slave control window: status word, four channel bus interrupter,
 * local nmi trigger and local cold restart trigger.
 * assumes vme strobes and switch arrive asynchronously and are
 * synchronised here; local status inputs come from the local clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vscsp_regs.svh"

// Overview of operation
// - byte read at offset 0x001001 triggers a level-7 local interrupt strobe.
// - that strobe drives handshake input one of the parallel interface timer.
// - eight byte interrupter registers, reachable only from vme, never locally.
// - four independent interrupter channels, each with enable, level and vector.
// - local and vme interrupt logic share no hardware path.
// - pending vme requests survive local restart; of the resets, only vme system reset clears them.
// - pending request clears when its matching acknowledge cycle completes.
// - word read at base returns status in bits 8 to 10, read only.
// - word read of interrupter adds status; word write equals odd byte write.
// - bit 8 reads 0 while local reset is low, else 1.
// - bit 9 reads 0 while local halt is low, else 1.
// - halted local processor restarts only by system reset or restart strobe.
// - bit 10 mirrors the watchdog output.
// - watchdog triggers stop while halted; recovery without board reset allowed.
// - control area in first 8 Kbyte; dual port ram from 0x2000 upward.
// - byte read at 0x001801 makes a local reset pulse long enough for cold start.
// - restart strobe leaves interrupter registers and request flops untouched.
// - respond to non-acknowledge cycles only with accepted modifier, address in range, switch at run.
// - select compares address 23 to 17 against configured base.

module vscsp_port
(
    // clock and vme system reset
    input wire logic clock,
    input wire logic sys_rst,
    // vme slave cycle (asynchronous)
    input wire logic vme_as_n,
    input wire logic vme_ds0_n,
    input wire logic vme_ds1_n,
    input wire logic vme_write_n,
    input wire logic vme_lword_n,
    input wire logic vme_iack_n,
    input wire logic [5:0] vme_am,
    input wire logic [23:1] vme_addr,
    input wire logic [15:0] vme_data_in,
    output logic [15:0] vme_data_out,
    output logic vme_data_oe,
    output logic vme_dtack,
    output logic [7:1] vme_irq,
    // board configuration
    input wire logic [6:0] base_sel,
    input wire logic [2:0] am_enable,
    input wire logic run_switch,
    // local side (local clock domain)
    input wire logic cpu_reset_n,
    input wire logic cpu_halt_n,
    input wire logic wdog_ok,
    input wire logic [3:0] local_irq_trigger,
    output logic handshake_input_one,
    output logic local_restart,
    output logic access_led,
    output logic dpr_select
);

    // ------------------------------------------------------------
    // synchronisers for vme pins and switch
    // ------------------------------------------------------------
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic dpr_sel_q;

    // two flops per asynchronous control level
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync_a <= 5'h1f;
            sync_b <= 5'h1f;
        end
        else
        begin
            sync_a <= {vme_as_n, vme_ds0_n, vme_ds1_n, vme_iack_n, ~run_switch};
            sync_b <= sync_a;
        end
    end

    logic as_s;
    logic ds_any;
    logic iack_s;
    logic run_s;
    assign as_s = ~sync_b[4];
    assign ds_any = ~sync_b[3] | ~sync_b[2];
    assign iack_s = ~sync_b[1];
    assign run_s = ~sync_b[0];

    // ------------------------------------------------------------
    // two flop capture of direction, modifier, address and data
    // ------------------------------------------------------------
    logic [45:0] bus_a;
    logic [45:0] bus_b;
    logic write_n_s;
    logic [5:0] am_s;
    logic [23:1] addr_s;
    logic [15:0] wdata_s;

    // qualifiers travel with the strobes, so decode sees one settled set
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bus_a <= {1'b1, 45'h0};
            bus_b <= {1'b1, 45'h0};
        end
        else
        begin
            bus_a <= {vme_write_n, vme_am, vme_addr, vme_data_in};
            bus_b <= bus_a;
        end
    end

    assign write_n_s = bus_b[45];
    assign am_s = bus_b[44:39];
    assign addr_s = bus_b[38:16];
    assign wdata_s = bus_b[15:0];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [16:0] ofs;
    logic am_ok;
    logic sel;
    logic ctrl_hit;
    logic word_acc;
    logic [2:0] bim_idx;
    logic [15:0] stat_word;

    // a0 is high when only the odd (low) lane strobes
    assign ofs = {addr_s[16:1], sync_b[2]};
    assign word_acc = ~sync_b[3] & ~sync_b[2];
    // accepted modifier set per jumper group
    assign am_ok = (am_enable == 3'h0)
        | (am_enable[0] & (am_s == `VSCSP_AM_NP_DATA | am_s == `VSCSP_AM_NP_PROG))
        | (am_enable[1] & (am_s == `VSCSP_AM_SV_DATA | am_s == `VSCSP_AM_SV_PROG))
        | (am_enable[2] & (am_s == `VSCSP_AM_EXTRA));
    // board select on a 128 Kbyte boundary
    assign sel = am_ok & run_s & (addr_s[23:17] == base_sel);
    assign ctrl_hit = sel & (ofs < `VSCSP_CTRL_LIMIT);
    assign bim_idx = addr_s[3:1];

    // status bits straight from local lines, read only
    always_comb
    begin
        stat_word = 16'h0000;
        stat_word[`VSCSP_STAT_RESET_BIT] = cpu_reset_n;
        stat_word[`VSCSP_STAT_HALT_BIT] = cpu_halt_n;
        stat_word[`VSCSP_STAT_WDOG_BIT] = wdog_ok;
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vscsp_pkg::vscsp_state_bundle_t cur;
    vscsp_pkg::vscsp_state_bundle_t next_cur;

    // matching acknowledge: level on a3..a1 equals a pending channel level
    logic [2:0] iack_level;
    logic [3:0] ack_hit;
    logic [3:0] ack_first;
    assign iack_level = addr_s[3:1];

    // per channel acknowledge match, lowest channel first
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_ack
            assign ack_hit[ch] = cur.irq_pend[ch] & (cur.irq_level[ch] == iack_level);
            if (ch == 0)
            begin : g_first
                assign ack_first[ch] = ack_hit[ch];
            end
            else
            begin : g_rest
                assign ack_first[ch] = ack_hit[ch] & ~|ack_hit[ch-1:0];
            end
        end
    endgenerate

    // next state of the whole port
    always_comb
    begin
        next_cur = cur;
        next_cur.nmi_pulse = 1'b0;
        next_cur.bim_cs = 1'b0;
        // restart pulse counts down, touching nothing of the interrupter
        if (cur.restart_active)
        begin
            if (cur.restart_cnt == `VSCSP_CNT_W'(1))
            begin
                next_cur.restart_active = 1'b0;
            end
            next_cur.restart_cnt = cur.restart_cnt - `VSCSP_CNT_W'(1);
        end
        case (cur.state)
            vscsp_pkg::VSCSP_IDLE:
            begin
                // acknowledge cycles carry the level, not the board address
                if (as_s & ds_any & iack_s & |ack_first)
                begin
                    // acknowledge completes: hand vector, drop request
                    for (int i = 0; i < 4; i++)
                    begin
                        if (ack_first[i])
                        begin
                            next_cur.rdata = {8'h00, cur.irq_vector[i]};
                            next_cur.irq_pend[i] = 1'b0;
                        end
                    end
                    next_cur.data_oe = 1'b1;
                    next_cur.dtack = 1'b1;
                    next_cur.sel_led = 1'b1;
                    next_cur.state = vscsp_pkg::VSCSP_ACK;
                end
                else if (as_s & ds_any & ~iack_s & ctrl_hit)
                begin
                    next_cur.sel_led = 1'b1;
                    next_cur.rdata = 16'h0000;
                    if (ofs <= `VSCSP_BIM_LAST)
                    begin
                        // interrupter bytes, odd addresses, vme side only
                        next_cur.bim_cs = 1'b1;
                        if (~write_n_s)
                        begin
                            // word write acts as the odd byte write
                            case (bim_idx[2])
                                1'b0:
                                begin
                                    next_cur.irq_enable[bim_idx[1:0]] = wdata_s[4];
                                    next_cur.irq_level[bim_idx[1:0]] = wdata_s[2:0];
                                end
                                default:
                                begin
                                    next_cur.irq_vector[bim_idx[1:0]] = wdata_s[7:0];
                                end
                            endcase
                        end
                        else
                        begin
                            next_cur.rdata[7:0] = bim_idx[2]
                                ? cur.irq_vector[bim_idx[1:0]]
                                : {3'h0, cur.irq_enable[bim_idx[1:0]], 1'b0,
                                   cur.irq_level[bim_idx[1:0]]};
                            if (word_acc)
                            begin
                                next_cur.rdata[15:8] = stat_word[15:8];
                            end
                        end
                    end
                    else if (write_n_s & word_acc & ofs == `VSCSP_OFS_STATUS)
                    begin
                        next_cur.rdata = stat_word;
                    end
                    else if (write_n_s & ofs == `VSCSP_OFS_NMI_STROBE)
                    begin
                        next_cur.nmi_pulse = 1'b1;
                    end
                    else if (write_n_s & ofs == `VSCSP_OFS_RESTART_STROBE)
                    begin
                        next_cur.restart_active = 1'b1;
                        next_cur.restart_cnt = `VSCSP_CNT_W'(`VSCSP_RESTART_CYC);
                    end
                    next_cur.data_oe = write_n_s;
                    next_cur.dtack = 1'b1;
                    next_cur.state = vscsp_pkg::VSCSP_ACK;
                end
            end
            vscsp_pkg::VSCSP_ACK:
            begin
                // hold answer until strobes go away
                if (~ds_any)
                begin
                    next_cur.dtack = 1'b0;
                    next_cur.data_oe = 1'b0;
                    next_cur.state = vscsp_pkg::VSCSP_WAIT_END;
                end
            end
            vscsp_pkg::VSCSP_WAIT_END:
            begin
                next_cur.sel_led = 1'b0;
                if (~as_s)
                begin
                    next_cur.state = vscsp_pkg::VSCSP_IDLE;
                end
            end
            default:
            begin
                next_cur.state = vscsp_pkg::VSCSP_IDLE;
            end
        endcase
        // local requests set pending after the acknowledge, so a set wins
        for (int i = 0; i < 4; i++)
        begin
            if (local_irq_trigger[i] & cur.irq_enable[i] & (cur.irq_level[i] != 3'h0))
            begin
                next_cur.irq_pend[i] = 1'b1;
            end
        end
        // request lines per level; no local interrupt path here
        next_cur.irq_out = 7'h00;
        for (int i = 0; i < 4; i++)
        begin
            if (next_cur.irq_pend[i] & next_cur.irq_level[i] != 3'h0)
            begin
                next_cur.irq_out[next_cur.irq_level[i]] = 1'b1;
            end
        end
    end

    // only the vme system reset clears the port state
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cur <= '0;
            dpr_sel_q <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
            dpr_sel_q <= as_s & ~iack_s & sel & (ofs >= `VSCSP_DPR_START);
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign vme_data_out = cur.rdata;
    assign vme_data_oe = cur.data_oe;
    assign vme_dtack = cur.dtack;
    assign vme_irq = cur.irq_out;
    assign handshake_input_one = cur.nmi_pulse;
    assign local_restart = cur.restart_active;
    assign access_led = cur.sel_led;
    assign dpr_select = dpr_sel_q;

endmodule
`default_nettype wire

// ==== src/vscsp_regs.svh ====
/*
 * constants of the vme slave control and status port: offsets, status bit
 * positions, decode fields and timing counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef VSCSP_REGS_SVH
`define VSCSP_REGS_SVH

// ------------------------------------------------------------
// board window offsets (byte addresses within the window)
// ------------------------------------------------------------
`define VSCSP_OFS_STATUS 17'h00000
`define VSCSP_OFS_NMI_STROBE 17'h01001
`define VSCSP_OFS_RESTART_STROBE 17'h01801
`define VSCSP_DPR_START 17'h02000
`define VSCSP_CTRL_LIMIT 17'h02000
`define VSCSP_BIM_LAST 17'h0000f

// ------------------------------------------------------------
// status word field positions
// ------------------------------------------------------------
`define VSCSP_STAT_RESET_BIT 8
`define VSCSP_STAT_HALT_BIT 9
`define VSCSP_STAT_WDOG_BIT 10

// ------------------------------------------------------------
// address modifier codes accepted
// ------------------------------------------------------------
`define VSCSP_AM_NP_DATA 6'h39
`define VSCSP_AM_NP_PROG 6'h3a
`define VSCSP_AM_SV_DATA 6'h3d
`define VSCSP_AM_SV_PROG 6'h3e
`define VSCSP_AM_EXTRA 6'h3f

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define VSCSP_CLK_NS 40
`define VSCSP_RESTART_NS 4000
`define VSCSP_RESTART_CYC ((`VSCSP_RESTART_NS + `VSCSP_CLK_NS - 1) / `VSCSP_CLK_NS)
`define VSCSP_CNT_W 8

`endif

// ==== tb/vscsp_port_asserts.sv ====
/*
 port checks of the vme control window.
 assumes one clock and the synchronous active high system reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vscsp_regs.svh"
module vscsp_port_asserts
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // vme side
    input wire logic vme_ds1_n,
    input wire logic vme_write_n,
    input wire logic vme_iack_n,
    input wire logic [23:1] vme_addr,
    input wire logic [15:0] vme_data_out,
    input wire logic vme_dtack,
    input wire logic [7:1] vme_irq,
    // configuration and local side
    input wire logic [6:0] base_sel,
    input wire logic run_switch,
    input wire logic cpu_reset_n,
    input wire logic cpu_halt_n,
    input wire logic wdog_ok,
    input wire logic handshake_input_one,
    input wire logic local_restart,
    input wire logic dpr_select
);
    logic [7:0] rcnt;
    logic [3:0] run_lo;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // restart pulse length and time with run off
    always_ff @(posedge clock)
    begin
        rcnt <= (sys_rst || !local_restart) ? 8'h00 : rcnt + 8'h01;
        run_lo <= (sys_rst || run_switch) ? 4'h0 : run_lo + {3'h0, run_lo != 4'hf};
    end
    property p_nmi_src;
        handshake_input_one |-> vme_write_n && vme_addr[16:1] == 16'h0800;
    endproperty
    a_nmi_src: assert property (p_nmi_src) else $error("nmi strobe without trigger");
    property p_nmi_one;
        handshake_input_one |=> !handshake_input_one;
    endproperty
    a_nmi_one: assert property (p_nmi_one) else $error("nmi strobe too long");
    property p_rst_len;
        $fell(local_restart) |-> rcnt == `VSCSP_RESTART_CYC;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("restart pulse length");
    property p_base;
        $rose(vme_dtack) && vme_iack_n |-> vme_addr[23:17] == base_sel;
    endproperty
    a_base: assert property (p_base) else $error("answer outside window");
    property p_run;
        $rose(vme_dtack) && vme_iack_n |-> run_lo < 4'h5;
    endproperty
    a_run: assert property (p_run) else $error("answer with run off");
    property p_ram;
        dpr_select |-> !vme_dtack && vme_addr[16:13] != 4'h0;
    endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_stat;
        $rose(vme_dtack) && vme_iack_n && vme_write_n && !vme_ds1_n && vme_addr[16:4] == 13'h0
            |-> vme_data_out[10:8] == {wdog_ok, cpu_halt_n, cpu_reset_n};
    endproperty
    a_stat: assert property (p_stat) else $error("status bits wrong");
    property p_clr;
        $fell(sys_rst) |-> vme_irq == 7'h00 && !local_restart;
    endproperty
    a_clr: assert property (p_clr) else $error("reset left requests");
endmodule
bind vscsp_port vscsp_port_asserts vscsp_port_asserts_inst
(
    .clock, .sys_rst, .vme_ds1_n, .vme_write_n, .vme_iack_n, .vme_addr,
    .vme_data_out, .vme_dtack, .vme_irq, .base_sel, .run_switch, .cpu_reset_n,
    .cpu_halt_n, .wdog_ok, .handshake_input_one, .local_restart, .dpr_select
);
`default_nettype wire

// ==== tb/vscsp_port_test.sv ====
/*
 self-checking bench of the vme control window.
 assumes design, checker and master model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module vscsp_port_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic run_switch = 1'b1;
    logic cpu_reset_n = 1'b1;
    logic cpu_halt_n = 1'b1;
    logic wdog_ok = 1'b1;
    logic vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n, vme_iack_n, vme_data_oe, vme_dtack;
    logic handshake_input_one, local_restart, access_led, dpr_select, ok;
    logic [5:0] vme_am;
    logic [23:1] vme_addr;
    logic [15:0] vme_data_in, vme_data_out, rd, v;
    logic [7:1] vme_irq;
    logic [6:0] base_sel = 7'h50;
    logic [3:0] local_irq_trigger = 4'h0;
    int n_fail = 0;
    int checked = 0;
    int seed = 32'h9e1a;
    int hs_n = 0;
    int rs_n = 0;
    int ram_n = 0;
    int led_n = 0;
    int n, lv;
    int regm[8];
    int pend_q[$];
    // 25 mhz clock
    always #20 clock = ~clock;
    vscsp_port vscsp_port_inst
    (
        .clock, .sys_rst, .vme_as_n, .vme_ds0_n, .vme_ds1_n, .vme_write_n,
        .vme_lword_n(1'b1), .vme_iack_n, .vme_am, .vme_addr, .vme_data_in,
        .vme_data_out, .vme_data_oe, .vme_dtack, .vme_irq, .base_sel,
        .am_enable(3'h3), .run_switch, .cpu_reset_n, .cpu_halt_n, .wdog_ok,
        .local_irq_trigger, .handshake_input_one, .local_restart, .access_led,
        .dpr_select
    );
    vscsp_vme_master vscsp_vme_master_inst
    (
        .clock, .dtack(vme_dtack), .rdata(vme_data_out), .as_n(vme_as_n),
        .ds0_n(vme_ds0_n), .ds1_n(vme_ds1_n), .write_n(vme_write_n),
        .iack_n(vme_iack_n), .am(vme_am), .addr(vme_addr), .wdata(vme_data_in)
    );
    // strobe and range activity seen at the ports
    always @(posedge clock)
    begin
        hs_n += (handshake_input_one === 1'b1);
        rs_n += (local_restart === 1'b1);
        ram_n += (dpr_select === 1'b1);
        led_n += (access_led === 1'b1 && vme_data_oe === 1'b1);
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic acc(input logic wr, wsz, input logic [16:0] ofs, input logic [15:0] d);
        vscsp_vme_master_inst.cyc(wr, 1'b0, wsz, {base_sel, ofs[16:1]}, d, rd, ok);
    endtask
    task automatic pulse(input int ch);
        tick(1);
        local_irq_trigger[ch] = 1'b1;
        tick(1);
        local_irq_trigger = 4'h0;
        tick(3);
    endtask
    function automatic logic [7:1] exp_irq();
        exp_irq = '0;
        foreach (pend_q[k]) exp_irq[pend_q[k]] = 1'b1;
    endfunction
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        tick(10);
        sys_rst = 1'b0;
        tick(3);
        `CHK("irq", 7'h00, vme_irq)
        for (int i = 0; i < 8; i++)
        begin
            {wdog_ok, cpu_halt_n, cpu_reset_n} = i[2:0];
            acc(1'b1, 1'b1, 17'h0, 16'hffff);
            acc(1'b0, 1'b1, 17'h0, 16'h0000);
            `CHK("status", i[2:0], rd[10:8])
        end
        done("status");
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            regm[i] = v[7:0] & (i < 4 ? 8'h17 : 8'hff);
            acc(1'b1, i[0], {13'h0, i[2:0], 1'b1}, v);
        end
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 1'b1, {13'h0, i[2:0], 1'b0}, 16'h0000);
            `CHK("reg", regm[i][7:0], rd[7:0] & (i < 4 ? 8'h17 : 8'hff))
            `CHK("reg status", 3'h7, rd[10:8])
        end
        done("registers");
        for (int ch = 0; ch < 4; ch++)
        begin
            lv = 7 - 2 * ch;
            v = $random(seed);
            acc(1'b1, 1'b0, {14'h0, ch[1:0], 1'b1}, 16'h0010 | lv[15:0]);
            acc(1'b1, 1'b0, {13'h0, 1'b1, ch[1:0], 1'b1}, v);
            pulse(ch);
            pend_q.push_back(lv);
            `CHK("irq", exp_irq(), vme_irq)
            if (ch == 3)
            begin
                n = rs_n;
                acc(1'b0, 1'b0, 17'h1801, 16'h0000);
                tick(110);
                `CHK("restart length", 100, rs_n - n)
                `CHK("irq kept", exp_irq(), vme_irq)
                acc(1'b0, 1'b1, 17'h6, 16'h0000);
                `CHK("reg kept", 8'h11, rd[7:0] & 8'h17)
            end
            vscsp_vme_master_inst.cyc(1'b0, 1'b1, 1'b0, {20'h0, lv[2:0]}, 16'h0, rd, ok);
            `CHK("vector", v[7:0], rd[7:0])
            void'(pend_q.pop_front());
            tick(2);
            `CHK("irq cleared", exp_irq(), vme_irq)
        end
        done("interrupter");
        n = hs_n;
        lv = led_n;
        acc(1'b0, 1'b0, 17'h1001, 16'h0000);
        tick(4);
        `CHK("read led", 1'b1, led_n > lv)
        `CHK("nmi pulses", 1, hs_n - n)
        `CHK("nmi answered", 1'b1, ok)
        `CHK("irq quiet", 7'h00, vme_irq)
        done("trigger");
        run_switch = 1'b0;
        tick(6);
        lv = led_n;
        acc(1'b0, 1'b1, 17'h0, 16'h0000);
        `CHK("run off", 1'b0, ok)
        `CHK("run off led", lv, led_n)
        run_switch = 1'b1;
        tick(4);
        vscsp_vme_master_inst.cyc(1'b0, 1'b0, 1'b1, {base_sel ^ 7'h01, 16'h0}, 16'h0, rd, ok);
        `CHK("other base", 1'b0, ok)
        vscsp_vme_master_inst.am_use = 6'h3f;
        acc(1'b0, 1'b1, 17'h0, 16'h0000);
        `CHK("modifier off", 1'b0, ok)
        vscsp_vme_master_inst.am_use = 6'h39;
        acc(1'b0, 1'b1, 17'h0, 16'h0000);
        `CHK("modifier on", 1'b1, ok)
        n = ram_n;
        acc(1'b0, 1'b1, 17'h2000, 16'h0000);
        `CHK("ram ack", 1'b0, ok)
        `CHK("ram select", 1'b1, ram_n > n)
        done("decode");
        acc(1'b1, 1'b0, 17'h1, 16'h0017);
        pulse(0);
        `CHK("irq set", 7'h40, vme_irq)
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        tick(3);
        `CHK("irq reset", 7'h00, vme_irq)
        done("reset");
        final_report;
    end
    // watchdog against a hang
    initial
    begin
        #2000000;
        n_fail++;
        final_report;
    end
endmodule
`default_nettype wire

// ==== tb/vscsp_vme_master.sv ====
/*
 vme master model running slave and acknowledge cycles.
 assumes one shared clock and an active high acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none
module vscsp_vme_master
(
    // clock and answer
    input wire logic clock,
    input wire logic dtack,
    input wire logic [15:0] rdata,
    // cycle lines
    output logic as_n,
    output logic ds0_n,
    output logic ds1_n,
    output logic write_n,
    output logic iack_n,
    output logic [5:0] am,
    output logic [23:1] addr,
    output logic [15:0] wdata
);
    logic [5:0] am_use = 6'h3d;
    // idle bus at time zero
    initial
    begin
        {as_n, ds0_n, ds1_n, write_n, iack_n} = 5'h1f;
        am = 6'h3d;
        addr = '0;
        wdata = 16'h5a5a;
    end
    // one cycle, held until acknowledge is sampled; ok low if refused
    task automatic cyc(input logic wr, ia, wsz, input logic [23:1] a,
        input logic [15:0] d, output logic [15:0] rd, output logic ok);
        @(posedge clock);
        #1;
        {am, addr, write_n, iack_n} = {am_use, a, !wr, !ia};
        wdata = wr ? d : ~wdata;
        {as_n, ds0_n, ds1_n} = {2'b00, !wsz};
        ok = 1'b0;
        rd = '0;
        repeat (12)
        begin
            @(posedge clock);
            if (dtack === 1'b1)
            begin
                ok = 1'b1;
                rd = rdata;
                break;
            end
        end
        #1;
        {as_n, ds0_n, ds1_n} = 3'h7;
        wdata = ~wdata; // released lines lose the last value
        repeat (5) @(posedge clock);
        #1;
    endtask
endmodule
`default_nettype wire
